// File: hdl/upi_pkg.sv
/*
  Shared constants for the serial and modem pin interface: register
  offsets, field positions, reset values, mode codes and state types.
  Assumes a single 50 MHz clock and an AXI4-Lite register bus.
*/
package upi_pkg;
  // Byte offsets inside one channel window
  localparam logic [5:0] OFF_TX     = 6'h00;
  localparam logic [5:0] OFF_RX     = 6'h04;
  localparam logic [5:0] OFF_MODEM  = 6'h08;
  localparam logic [5:0] OFF_ALT    = 6'h0c;
  localparam logic [5:0] OFF_FEAT   = 6'h10;
  localparam logic [5:0] OFF_ENH    = 6'h14;
  localparam logic [5:0] OFF_INTEN  = 6'h18;
  localparam logic [5:0] OFF_STATUS = 6'h1c;
  localparam logic [5:0] OFF_DIV    = 6'h20;
  // Address bit that picks channel B, bit that must be zero
  localparam int CH_BIT    = 6;
  localparam int TOP_BIT   = 7;
  // Field positions
  localparam int MC_DTR    = 0;
  localparam int MC_RTS    = 1;
  localparam int MC_GPO    = 3;
  localparam int MC_IR     = 6;
  localparam int ALT_LO    = 1;
  localparam int FC_RXINV  = 2;
  localparam int FC_HDX    = 3;
  localparam int EF_ARTS   = 6;
  localparam int EF_ACTS   = 7;
  // Multi-function output selections
  localparam logic [1:0] MF_GPO   = 2'h0;
  localparam logic [1:0] MF_BAUD  = 2'h1;
  localparam logic [1:0] MF_RXRDY = 2'h2;
  // Reset values
  localparam logic [7:0]  REG_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h001b;
  // Timing counts in 16x ticks, last bit index and bus response codes
  localparam logic [3:0] IR_PULSE = 4'h3;
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] SUB_MID  = 4'h7;
  localparam logic [3:0] IR_HOLD  = 4'hf;
  localparam logic [3:0] LAST_BIT = 4'h9;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} upi_tx_e;
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_RECV = 2'b10} upi_rx_e;
endpackage : upi_pkg

// File: hdl/upi_pins.sv
/*
  Serial and modem pin interface for two UART channels, with a small
  transmit FIFO and an AXI4-Lite register slave.
  Assumes pins arrive asynchronous and srst is synchronous to ref_clk.
*/
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
// What this block does
// - Multi-function output picks one of three functions
// - General output low when modem bit 3 set
// - Modem bit 3 clears on reset
// - Baud function shows the 16x clock
// - Receive-ready function is active-low data-ready
// - Standard mode: transmit idles high, high in reset
// - Infrared mode: encoder/decoder used, transmit idles low
// - Infrared receive idles low, optional inversion
// - Request-to-send active low, auto flow control
// - Half-duplex mode steers transceiver via request-to-send
// - Clear-to-send active low, gates transmit automatically
// - Terminal-ready active low software output
// - Data-set-ready and ring sampled, readable raw

module upi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } upi_fifo_s;
  upi_fifo_s q, d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  // Pointer and count update
  always_comb begin
    d = q;
    inReady = q.cnt != (AW+1)'(DEPTH);
    outValid = q.cnt != '0;
    outData = mem[q.rp];
    push = inValid && inReady;
    pop = outValid && outReady;
    if (push) d.wp = (q.wp == AW'(DEPTH-1)) ? '0 : q.wp + 1'b1;
    if (pop) d.rp = (q.rp == AW'(DEPTH-1)) ? '0 : q.rp + 1'b1;
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State and storage
  always_ff @(posedge ref_clk) begin
    if (srst) q <= '0;
    else q <= d;
    if (push) mem[q.wp] <= inData;
  end
endmodule : upi_fifo

module upi_channel
  import upi_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        wrEn,
  input  wire logic [5:0]  wrOff,
  input  wire logic [31:0] wrData,
  input  wire logic [1:0]  wrStrb,
  input  wire logic        rdEn,
  input  wire logic [5:0]  rdOff,
  output logic      [31:0] rdData,
  output logic             txReady,
  output logic             serialOut,
  input  wire logic        serialIn,
  output logic             requestToSendN,
  input  wire logic        clearToSendN,
  output logic             terminalReadyN,
  input  wire logic        dataSetReadyN,
  input  wire logic        ringIndicatorN,
  output logic             multiFunctionOutN
);
  typedef struct packed {
    logic [7:0]  modem;
    logic [7:0]  alt;
    logic [7:0]  feat;
    logic [7:0]  enh;
    logic [7:0]  inten;
    logic [15:0] div;
    logic [15:0] bcnt;
    logic        tick;
    logic [3:0]  meta;
    logic [3:0]  sync;
    upi_tx_e     txSt;
    logic [9:0]  txSh;
    logic [3:0]  txBit;
    logic [3:0]  txSub;
    logic [3:0]  irHold;
    upi_rx_e     rxSt;
    logic [7:0]  rxSh;
    logic [3:0]  rxBit;
    logic [3:0]  rxSub;
    logic [7:0]  rxData;
    logic        rxFull;
    logic        overrun;
    logic        txPin;
    logic        rtsN;
    logic        dtrN;
    logic        mfN;
  } upi_ch_s;
  upi_ch_s q, d;
  logic       fifoValid, fifoPop, ctsOk, irMode, rxIn, lineLvl, baudHi;
  logic [7:0] fifoData;

  upi_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .inValid  (wrEn && wrOff == OFF_TX && wrStrb[0]),
    .inReady  (txReady),
    .inData   (wrData[7:0]),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoData)
  );

  assign serialOut = q.txPin;
  assign requestToSendN = q.rtsN;
  assign terminalReadyN = q.dtrN;
  assign multiFunctionOutN = q.mfN;

  // Channel next state, pin drive and read mux
  always_comb begin
    d = q;
    irMode = q.modem[MC_IR];
    ctsOk = !q.enh[EF_ACTS] || !q.sync[1];
    fifoPop = q.txSt == TX_IDLE && q.tick && ctsOk && fifoValid;
    // Software writes
    if (wrEn && wrStrb[0]) begin
      case (wrOff)
        OFF_MODEM: d.modem = wrData[7:0];
        OFF_ALT:   d.alt = wrData[7:0];
        OFF_FEAT:  d.feat = wrData[7:0];
        OFF_ENH:   d.enh = wrData[7:0];
        OFF_INTEN: d.inten = wrData[7:0];
        OFF_DIV:   d.div[7:0] = wrData[7:0];
        default:   d.div = d.div;
      endcase
    end
    if (wrEn && wrStrb[1] && wrOff == OFF_DIV) d.div[15:8] = wrData[15:8];
    // 16x tick divider
    d.tick = 1'b0;
    if (q.bcnt >= q.div - 16'h0001) begin
      d.bcnt = '0;
      d.tick = 1'b1;
    end else begin
      d.bcnt = q.bcnt + 16'h0001;
    end
    baudHi = q.bcnt >= {1'b0, q.div[15:1]};
    // Input synchronisers
    d.meta = {dataSetReadyN, ringIndicatorN, clearToSendN, serialIn};
    d.sync = q.meta;
    // Receive path, optional inversion and infrared decode
    rxIn = q.sync[0] ^ (irMode && q.feat[FC_RXINV]);
    if (q.tick) begin
      if (rxIn) d.irHold = IR_HOLD;
      else if (q.irHold != '0) d.irHold = q.irHold - 4'h1;
    end
    lineLvl = irMode ? !(rxIn || q.irHold != '0) : rxIn;
    // Reading the received byte frees the holder
    if (rdEn && rdOff == OFF_RX) begin
      d.rxFull = 1'b0;
      d.overrun = 1'b0;
    end
    // Receiver, idle line is high after decode
    if (q.tick) begin
      case (q.rxSt)
        RX_IDLE: begin
          if (!lineLvl) begin
            d.rxSt = RX_RECV;
            d.rxSub = '0;
            d.rxBit = '0;
          end
        end
        RX_RECV: begin
          d.rxSub = q.rxSub + 4'h1;
          if (q.rxSub == SUB_MID) begin
            d.rxBit = q.rxBit + 4'h1;
            if (q.rxBit == '0 && lineLvl) d.rxSt = RX_IDLE;
            else if (q.rxBit == LAST_BIT) begin
              d.rxSt = RX_IDLE;
              if (lineLvl) begin
                d.rxData = q.rxSh;
                d.overrun = q.rxFull;
                d.rxFull = 1'b1;
              end
            end else if (q.rxBit != '0) begin
              d.rxSh = {lineLvl, q.rxSh[7:1]};
            end
          end
        end
        default: d.rxSt = RX_IDLE;
      endcase
    end
    // Transmitter
    case (q.txSt)
      TX_IDLE: begin
        if (fifoPop) begin
          d.txSt = TX_SEND;
          d.txSh = {1'b1, fifoData, 1'b0};
          d.txBit = '0;
          d.txSub = '0;
        end
      end
      TX_SEND: begin
        if (q.tick) begin
          d.txSub = q.txSub + 4'h1;
          if (q.txSub == SUB_LAST) begin
            d.txSh = {1'b1, q.txSh[9:1]};
            d.txBit = q.txBit + 4'h1;
            if (q.txBit == LAST_BIT) d.txSt = TX_IDLE;
          end
        end
      end
      default: d.txSt = TX_IDLE;
    endcase
    // Transmit pin: raw bits or short pulses for zeros
    if (irMode) begin
      d.txPin = q.txSt == TX_SEND && !q.txSh[0]
                && q.txSub < IR_PULSE;
    end else begin
      d.txPin = q.txSt == TX_IDLE || q.txSh[0];
    end
    // Request-to-send: direction, auto flow or software
    if (q.feat[FC_HDX]) begin
      d.rtsN = q.txSt != TX_SEND;
    end else if (q.enh[EF_ARTS]) begin
      d.rtsN = !(q.modem[MC_RTS] && !q.rxFull);
    end else begin
      d.rtsN = !q.modem[MC_RTS];
    end
    d.dtrN = !q.modem[MC_DTR];
    // Multi-function output selection
    case (q.alt[ALT_LO+1:ALT_LO])
      MF_GPO:   d.mfN = !q.modem[MC_GPO];
      MF_BAUD:  d.mfN = baudHi;
      MF_RXRDY: d.mfN = !q.rxFull;
      default:  d.mfN = 1'b1;
    endcase
    // Register read mux
    case (rdOff)
      OFF_TX:     rdData = {23'h0, !txReady, 8'h00};
      OFF_RX:     rdData = {22'h0, q.overrun, q.rxFull, q.rxData};
      OFF_MODEM:  rdData = {24'h0, q.modem};
      OFF_ALT:    rdData = {24'h0, q.alt};
      OFF_FEAT:   rdData = {24'h0, q.feat};
      OFF_ENH:    rdData = {24'h0, q.enh};
      OFF_INTEN:  rdData = {24'h0, q.inten};
      OFF_STATUS: rdData = {25'h0, q.sync[2], q.sync[3],
                            q.sync[1], 1'b0, !q.sync[2],
                            !q.sync[3], !q.sync[1]};
      OFF_DIV:    rdData = {16'h0, q.div};
      default:    rdData = 32'h0;
    endcase
  end

  // Channel state register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
      q.modem <= REG_RST;
      q.div <= DIV_RST;
      q.meta <= 4'hf;
      q.sync <= 4'hf;
      q.txSt <= TX_IDLE;
      q.rxSt <= RX_IDLE;
      q.txSh <= 10'h3ff;
      q.txPin <= 1'b1;
      q.rtsN <= 1'b1;
      q.dtrN <= 1'b1;
      q.mfN <= 1'b1;
    end else begin
      q <= d;
    end
  end
endmodule : upi_channel

module upi_pins
  import upi_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [1:0]       serialOut,
  input  wire logic [1:0]  serialIn,
  output logic [1:0]       requestToSendN,
  input  wire logic [1:0]  clearToSendN,
  output logic [1:0]       terminalReadyN,
  input  wire logic [1:0]  dataSetReadyN,
  input  wire logic [1:0]  ringIndicatorN,
  output logic [1:0]       multiFunctionOutN
);
  typedef struct packed {
    logic        awHave;
    logic        wHave;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        rdPend;
    logic [7:0]  raddr;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } upi_bus_s;
  upi_bus_s q, d;
  logic [1:0]  wrEn, rdEn, txReady;
  logic [31:0] rdData [2];

  // Address must be word aligned, in window and a known offset
  function automatic logic mapped(input logic [7:0] a);
    logic [5:0] o;
    o = a[5:0];
    mapped = !a[TOP_BIT] && o[1:0] == 2'h0 && o <= OFF_DIV;
  endfunction : mapped

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;

  // Bus slave next state
  always_comb begin
    d = q;
    wrEn = 2'b00;
    rdEn = 2'b00;
    if (s_axi_awvalid && q.awready) begin
      d.awHave = 1'b1;
      d.awready = 1'b0;
      d.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.wHave = 1'b1;
      d.wready = 1'b0;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    // Transmit writes wait for FIFO room
    if (q.awHave && q.wHave && !q.bvalid
        && !(q.waddr[5:0] == OFF_TX && mapped(q.waddr)
             && !txReady[q.waddr[CH_BIT]])) begin
      wrEn[q.waddr[CH_BIT]] = mapped(q.waddr);
      d.bvalid = 1'b1;
      d.bresp = mapped(q.waddr) ? RESP_OK : RESP_ERR;
      d.awHave = 1'b0;
      d.wHave = 1'b0;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end
    if (s_axi_arvalid && q.arready) begin
      d.arready = 1'b0;
      d.rdPend = 1'b1;
      d.raddr = s_axi_araddr;
    end
    if (q.rdPend) begin
      rdEn[q.raddr[CH_BIT]] = mapped(q.raddr);
      d.rdPend = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = mapped(q.raddr) ? RESP_OK : RESP_ERR;
      d.rdata = mapped(q.raddr) ? rdData[q.raddr[CH_BIT]] : 32'h0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end
  end

  // Bus slave state register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // One independent pin interface per channel
  for (genvar c = 0; c < 2; c++) begin : g_ch
    upi_channel u_ch (
      .ref_clk           (ref_clk),
      .srst              (srst),
      .wrEn              (wrEn[c]),
      .wrOff             (q.waddr[5:0]),
      .wrData            (q.wdata),
      .wrStrb            (q.wstrb[1:0]),
      .rdEn              (rdEn[c]),
      .rdOff             (q.raddr[5:0]),
      .rdData            (rdData[c]),
      .txReady           (txReady[c]),
      .serialOut         (serialOut[c]),
      .serialIn          (serialIn[c]),
      .requestToSendN    (requestToSendN[c]),
      .clearToSendN      (clearToSendN[c]),
      .terminalReadyN    (terminalReadyN[c]),
      .dataSetReadyN     (dataSetReadyN[c]),
      .ringIndicatorN    (ringIndicatorN[c]),
      .multiFunctionOutN (multiFunctionOutN[c])
    );
  end
endmodule : upi_pins

// File: testbench/upi_monitor.sv
/* Checker for upi_pins pins and register effects.
   Assumes bound to upi_pins, one clock, AXI driven per protocol. */
module upi_monitor
  import upi_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  serialOut,
  input wire logic [1:0]  clearToSendN,
  input wire logic [1:0]  dataSetReadyN,
  input wire logic [1:0]  ringIndicatorN,
  input wire logic [1:0]  terminalReadyN,
  input wire logic [1:0]  multiFunctionOutN
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] wA;
    logic [7:0] wD;
    logic [7:0] rA;
    logic [1:0] alt0;
  } upi_mon_s;
  upi_mon_s shadow_q;
  upi_mon_s shadow_d;
  logic     wrDone;
  logic     rdDone;
  // Handshake strobes
  assign wrDone = s_axi_bvalid && s_axi_bready;
  assign rdDone = s_axi_rvalid && s_axi_rready;
  // Last addresses, write byte and channel A function field
  always_comb begin
    shadow_d = shadow_q;
    if (s_axi_awvalid && s_axi_awready) shadow_d.wA = s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) shadow_d.wD = s_axi_wdata[7:0];
    if (s_axi_arvalid && s_axi_arready) shadow_d.rA = s_axi_araddr;
    if (wrDone && shadow_q.wA == 8'h0c) shadow_d.alt0 = shadow_q.wD[2:1];
  end
  // Shadow register
  always_ff @(posedge ref_clk) begin
    if (srst) shadow_q <= '0;
    else shadow_q <= shadow_d;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_reset_idle: assert property (
    $fell(srst) |-> serialOut == 2'b11 && multiFunctionOutN == 2'b11
      && terminalReadyN == 2'b11) else $error("pins not idle after reset");
  a_dtr_follow: assert property (
    wrDone && shadow_q.wA == 8'h08
      |-> ##[1:3] terminalReadyN[0] == ~shadow_q.wD[0])
    else $error("terminal ready pin wrong");
  a_gpo_follow: assert property (
    wrDone && shadow_q.wA == 8'h08 && shadow_q.alt0 == MF_GPO
      |-> ##[1:3] multiFunctionOutN[0] == ~shadow_q.wD[3])
    else $error("general output pin wrong");
  a_chan_apart: assert property (
    wrDone && shadow_q.wA == 8'h08 |-> ##1 $stable(terminalReadyN[1]) [*3])
    else $error("channel B moved on channel A write");
  a_tx_idle_mode: assert property (
    wrDone && shadow_q.wA == 8'h08 |-> ##[1:3] serialOut[0] == ~shadow_q.wD[6])
    else $error("transmit idle level wrong");
  a_baud_runs: assert property (
    shadow_q.alt0 == MF_BAUD |-> ##[1:60] $changed(multiFunctionOutN[0]))
    else $error("baud clock output stuck");
  a_rxrdy_clear: assert property (
    rdDone && shadow_q.rA == 8'h04 && shadow_q.alt0 == MF_RXRDY
      |-> ##[1:3] multiFunctionOutN[0]) else $error("receive ready stuck");
  a_status_raw: assert property (
    s_axi_rvalid && shadow_q.rA == 8'h1c |-> s_axi_rdata[6:4] ==
      {ringIndicatorN[0], dataSetReadyN[0], clearToSendN[0]}
      && s_axi_rdata[2:0] == ~s_axi_rdata[6:4]) else $error("status wrong");
  c_tx_write: cover property (wrDone && shadow_q.wA == 8'h00);
  c_baud_mode: cover property (shadow_q.alt0 == MF_BAUD);
  c_rx_read: cover property (rdDone && shadow_q.rA == 8'h04);
endmodule : upi_monitor

bind upi_pins upi_monitor mon (.*);

// File: testbench/upi_far_end.sv
/* Far-end modem model for channel A of upi_pins.
   Assumes the bench sets the divisor so a bit lasts BIT_CYC cycles. */
module upi_far_end #(
  parameter int BIT_CYC = 32
) (
  input  wire logic ref_clk,
  input  wire logic txLine,
  output logic      rxLine,
  output logic      ctsN,
  output logic      dsrN,
  output logic      riN
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle line high, status lines not asserted
  initial begin
    rxLine = 1'b1;
    ctsN = 1'b1;
    dsrN = 1'b1;
    riN = 1'b1;
  end
  // Active-low status lines
  task automatic set_status(input logic c, input logic d, input logic r);
    @(posedge ref_clk);
    ctsN <= c;
    dsrN <= d;
    riN <= r;
  endtask : set_status
  // Park the receive line at a level
  task automatic hold(input logic v);
    @(posedge ref_clk);
    rxLine <= v;
  endtask : hold
  // One 8N1 frame LSB first; infrared 3/16 bit pulse on 0 bits, inv flips
  task automatic send(input logic [7:0] b, input logic ir,
                      input logic inv = 1'b0);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int c = 0; c < BIT_CYC; c++) begin
        @(posedge ref_clk);
        if (!ir) rxLine <= f[i];
        else rxLine <= (!f[i] && c < BIT_CYC * 3 / 16) ^ inv;
      end
    end
    @(posedge ref_clk);
    rxLine <= !ir || inv;
  endtask : send
  // Take one frame off the transmit line; ok low on timeout or bad stop
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    while (txLine && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (BIT_CYC / 2) @(negedge ref_clk);
    ok = !txLine && n < 4000;
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(negedge ref_clk);
      b[i] = txLine;
    end
    repeat (BIT_CYC) @(negedge ref_clk);
    ok = ok && txLine;
  endtask : recv
endmodule : upi_far_end

// File: testbench/upi_tb.sv
/* Self-checking bench for upi_pins over AXI4-Lite.
   Assumes channel A faces upi_far_end, channel B pins sit idle. */
`define CHK(nm, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
    end \
  end

module testbench
  import upi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h3;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [1:0]  serialOut, requestToSendN, terminalReadyN;
  logic [1:0]  multiFunctionOutN, serialIn, clearToSendN;
  logic [1:0]  dataSetReadyN, ringIndicatorN;
  logic        rxA, ctsA, dsrA, riA;
  int          n_mismatch = 0;
  int          check_count = 0;
  // Channel A from the far end, channel B idle
  assign serialIn = {1'b1, rxA};
  assign clearToSendN = {1'b1, ctsA};
  assign dataSetReadyN = {1'b1, dsrA};
  assign ringIndicatorN = {1'b1, riA};
  upi_pins DUT (.*);
  upi_far_end #(.BIT_CYC(32)) far (.ref_clk, .txLine(serialOut[0]),
    .rxLine(rxA), .ctsN(ctsA), .dsrN(dsrA), .riN(riA));
  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  task automatic report_and_stop;
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wt
  // Write one word, check the response code
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OK);
    logic ta, tw, tb;
    int   n;
    n = 0;
    tb = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb) begin
      @(negedge ref_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      if (tb) `CHK("bresp", er, s_axi_bresp)
      @(posedge ref_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      if (++n > 500) begin
        n_mismatch++;
        report_and_stop;
      end
    end
  endtask : wr
  // Read one word, check the response code
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    input logic [1:0] er = RESP_OK);
    logic ta, tr;
    int   n;
    n = 0;
    tr = 1'b0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr) begin
      @(negedge ref_clk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      if (tr) `CHK("rresp", er, s_axi_rresp)
      @(posedge ref_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
      if (++n > 500) begin
        n_mismatch++;
        report_and_stop;
      end
    end
  endtask : rd

  task automatic t_reset;
    logic [31:0] d;
    `CHK("tx", 2'b11, serialOut)
    `CHK("mf", 2'b11, multiFunctionOutN)
    `CHK("dtr", 2'b11, terminalReadyN)
    `CHK("rts", 2'b11, requestToSendN)
    rd(8'h08, d);
    `CHK("modemA", 32'h0, d)
    rd(8'h48, d);
    `CHK("modemB", 32'h0, d)
    rd(8'h20, d);
    `CHK("divisor", {16'h0, DIV_RST}, d)
    rd(8'h24, d, RESP_ERR);
    `CHK("hole", 32'h0, d)
    wr(8'h80, 32'h1, RESP_ERR);
  endtask : t_reset

  task automatic t_modem;
    wr(8'h08, 32'h0b);
    wt(3);
    `CHK("dtr", 2'b10, terminalReadyN)
    `CHK("mf", 2'b10, multiFunctionOutN)
    `CHK("rts", 2'b10, requestToSendN)
    wr(8'h08, 32'h0);
    wt(3);
    `CHK("mfOff", 2'b11, multiFunctionOutN)
  endtask : t_modem

  task automatic t_mf;
    int   rises;
    logic p;
    wr(8'h20, 32'h4);
    wr(8'h0c, 32'h2);
    wt(4);
    rises = 0;
    p = multiFunctionOutN[0];
    repeat (64) begin
      @(negedge ref_clk);
      if (multiFunctionOutN[0] && !p) rises++;
      p = multiFunctionOutN[0];
    end
    `CHK("baud", 1'b1, rises inside {[15:17]})
    wr(8'h0c, 32'h4);
    wr(8'h08, 32'h08);
    wt(3);
    `CHK("rxrdyIdle", 1'b1, multiFunctionOutN[0])
    wr(8'h0c, 32'h0);
    wt(3);
    `CHK("gpo", 1'b0, multiFunctionOutN[0])
    wr(8'h08, 32'h0);
  endtask : t_mf

  task automatic t_rx;
    logic [31:0] d;
    wr(8'h20, 32'h2);
    wr(8'h0c, 32'h4);
    wr(8'h14, 32'h40);
    wr(8'h08, 32'h02);
    wt(3);
    `CHK("rtsOn", 1'b0, requestToSendN[0])
    far.send(8'ha5, 1'b0);
    wt(4);
    `CHK("rxrdy", 1'b0, multiFunctionOutN[0])
    `CHK("rtsFull", 1'b1, requestToSendN[0])
    rd(8'h04, d);
    `CHK("rxByte", 32'h1a5, d)
    wt(3);
    `CHK("rxrdyOff", 1'b1, multiFunctionOutN[0])
    `CHK("rtsBack", 1'b0, requestToSendN[0])
    wr(8'h14, 32'h0);
    wr(8'h0c, 32'h0);
    wr(8'h08, 32'h0);
  endtask : t_rx

  task automatic t_tx;
    logic [31:0] d;
    logic [7:0]  b;
    logic        ok;
    wr(8'h14, 32'h80);
    for (int i = 1; i <= 4; i++) wr(8'h00, 32'h11 * i);
    wt(64);
    `CHK("ctsHold", 1'b1, serialOut[0])
    rd(8'h00, d);
    `CHK("full", 1'b1, d[8])
    far.set_status(1'b1, 1'b0, 1'b0);
    wt(4);
    rd(8'h1c, d);
    `CHK("status", 32'h16, d)
    far.set_status(1'b0, 1'b1, 1'b1);
    for (int i = 1; i <= 4; i++) begin
      far.recv(b, ok);
      `CHK("txByte", {1'b1, 8'(8'h11 * i)}, {ok, b})
    end
    rd(8'h00, d);
    `CHK("notFull", 1'b0, d[8])
    wr(8'h14, 32'h0);
  endtask : t_tx

  task automatic t_ir;
    logic [31:0] d;
    int          hi;
    far.hold(1'b0);
    wr(8'h08, 32'h40);
    wt(3);
    `CHK("irIdle", 1'b0, serialOut[0])
    wt(400);
    rd(8'h04, d);
    far.send(8'h5a, 1'b1);
    wt(8);
    rd(8'h04, d);
    `CHK("irByte", 32'h15a, d)
    wr(8'h00, 32'hff);
    hi = 0;
    repeat (400) begin
      @(negedge ref_clk);
      if (serialOut[0]) hi++;
    end
    `CHK("irPulse", 6, hi)
    wr(8'h10, 32'h04);
    far.hold(1'b1);
    wt(400);
    rd(8'h04, d);
    far.send(8'hc3, 1'b1, 1'b1);
    wt(8);
    rd(8'h04, d);
    `CHK("irInv", 32'h1c3, d)
    wr(8'h10, 32'h0);
    wr(8'h08, 32'h0);
    wt(400);
    rd(8'h04, d);
  endtask : t_ir

  task automatic t_hdx;
    logic [7:0] b;
    logic       ok;
    int         lo;
    wr(8'h10, 32'h08);
    wr(8'h00, 32'h55);
    lo = 0;
    fork
      far.recv(b, ok);
      repeat (400) begin
        @(negedge ref_clk);
        if (!requestToSendN[0]) lo++;
      end
    join
    `CHK("hdxByte", 9'h155, {ok, b})
    `CHK("hdxLow", 1'b1, lo inside {[300:340]})
    `CHK("hdxIdle", 1'b1, requestToSendN[0])
    wr(8'h10, 32'h0);
  endtask : t_hdx

  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    wt(1);
    t_reset;
    t_modem;
    t_mf;
    t_rx;
    t_tx;
    t_ir;
    t_hdx;
    report_and_stop;
  end
endmodule : testbench
